// ### hdl/config_fifo.v
// Byte FIFO between pin capture and consumer.
// Assumes one clock, synchronous active-low reset, DEPTH a power of two.
`timescale 1ns/1ps
module config_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16
)(
    input wire clk_in,
    input wire resetn_in,
    input wire [WIDTH-1:0] in_data_in,
    input wire in_valid_in,
    output wire in_ready_out,
    output reg [WIDTH-1:0] out_data_out,
    output reg out_valid_out,
    input wire out_ready_in
);
localparam AW = $clog2(DEPTH);
localparam [AW:0] FULL_COUNT = DEPTH;
reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_q;
reg [AW-1:0] rd_q;
reg [AW:0] count_q;
wire push = in_valid_in && in_ready_out;
// Refill the output register when empty or draining.
wire load = (count_q != {(AW+1){1'b0}}) && (!out_valid_out || out_ready_in);

assign in_ready_out = (count_q != FULL_COUNT);

always @(posedge clk_in)
begin
    if (!resetn_in)
    begin
        wr_q <= {AW{1'b0}};
        rd_q <= {AW{1'b0}};
        count_q <= {(AW+1){1'b0}};
        out_data_out <= {WIDTH{1'b0}};
        out_valid_out <= 1'b0;
    end
    else
    begin
        if (push)
        begin
            mem[wr_q] <= in_data_in;
            wr_q <= wr_q + 1'b1;
        end
        if (load)
        begin
            out_data_out <= mem[rd_q];
            rd_q <= rd_q + 1'b1;
            out_valid_out <= 1'b1;
        end
        else if (out_ready_in)
        begin
            out_valid_out <= 1'b0;
        end
        count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    end
end
endmodule // config_fifo

// ### hdl/config_port_defines.vh
// Constants of the pin controller.
// Assumes inclusion by bare name.
// What this block does
// - Straps are latched at the ready line's rising edge.
// - Low program request restarts configuration.
// - Ready line held low while clearing, then released.
// - Done line released when loading ends and startup runs.
// - Master modes drive the link clock; slave modes receive it.
// - A test port command makes it the configuration port.
// - The first selected port stays locked until power-up reset.
// - SPI data bit 0: output as master, input as slave.
// - Shared pins go to user logic after configuration.
// - Parallel mode: busy pin shows no byte can be taken.
// - SPI master drives flash select; serial modes send serial data out.
// - Test port state machine runs on test clock, steered by mode select.
`ifndef CONFIG_PORT_DEFINES_VH
`define CONFIG_PORT_DEFINES_VH

`define MCLK_PERIOD_NS 5
`define CONFIG_CLOCK_HALF_NS 50
`define CONFIG_CLOCK_HALF_CYC ((`CONFIG_CLOCK_HALF_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define CLEAR_NS 2000
`define CLEAR_CYC ((`CLEAR_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define STARTUP_NS 400
`define STARTUP_CYC ((`STARTUP_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`define MODE_MASTER_SPI 3'h0
`define MODE_SLAVE_SPI 3'h1
`define MODE_MASTER_SERIAL 3'h2
`define MODE_SLAVE_SERIAL 3'h3
`define MODE_PARALLEL 3'h4
`define MODE_RESET 3'h7

`define LOCK_NONE 2'h0
`define LOCK_PINS 2'h1
`define LOCK_JTAG 2'h2

`define IR_BYPASS 8'hFF
`define IR_CAPTURE 8'h01
`define IR_CFG_ENABLE 8'hC6
`define IR_CFG_LOAD 8'h7A

`define FLASH_READ_CMD 32'h03000000
`define CMD_BITS 6'h20

`endif

// ### hdl/config_port_pin_control.v
// Configuration pin controller: straps, ready, done,
// link clock, data ports and test port.
// Assumes asynchronous pins; open-drain and
// two-way wires are resolved outside.
`timescale 1ns/1ps
`include "config_port_defines.vh"
module config_port_pin_control #(
    parameter FIFO_DEPTH = 16,
    parameter [15:0] CONFIG_BYTES = 16'h0010,
    parameter [15:0] CLEAR_CYCLES = `CLEAR_CYC,
    parameter [15:0] STARTUP_CYCLES = `STARTUP_CYC
)(
    input wire mclk_in,
    input wire resetn_in,
    input wire program_request_n_in,
    input wire [2:0] cfg_mode_in,
    input wire ready_for_config_n_in,
    output reg ready_for_config_n_out,
    output reg ready_for_config_n_oe_out,
    input wire done_in,
    output reg done_out,
    output reg done_oe_out,
    input wire config_clock_in,
    output reg config_clock_out,
    output reg config_clock_oe_out,
    input wire port_select_n_in,
    input wire second_select_n_in,
    input wire parallel_write_enable_n_in,
    output reg shared_busy_pin_out,
    output reg shared_busy_pin_oe_out,
    output reg serial_out_or_flash_select_out,
    output reg serial_out_or_flash_select_oe_out,
    input wire [7:0] config_data_in,
    output reg config_data_bit0_out,
    output reg config_data_bit0_oe_out,
    input wire tck_in,
    input wire tms_in,
    input wire tdi_in,
    output reg tdo_out,
    output reg tdo_oe_out,
    output wire [7:0] cfg_byte_out,
    output wire cfg_byte_valid_out,
    input wire cfg_byte_ready_in,
    output reg [2:0] cfg_mode_out,
    output reg [1:0] port_lock_out,
    output reg config_active_out,
    output reg user_mode_out,
    output reg overrun_out
);

////////////////////////////////////////////////////////////////////////////////

localparam SYNC_W = 21;
localparam ST_CLEAR = 6'h01;
localparam ST_WAIT = 6'h02;
localparam ST_LOAD = 6'h04;
localparam ST_DONE = 6'h08;
localparam ST_START = 6'h10;
localparam ST_USER = 6'h20;
localparam T_RESET = 16'h0001;
localparam T_IDLE = 16'h0002;
localparam T_SEL_DR = 16'h0004;
localparam T_CAP_DR = 16'h0008;
localparam T_SH_DR = 16'h0010;
localparam T_EX1_DR = 16'h0020;
localparam T_PA_DR = 16'h0040;
localparam T_EX2_DR = 16'h0080;
localparam T_UP_DR = 16'h0100;
localparam T_SEL_IR = 16'h0200;
localparam T_CAP_IR = 16'h0400;
localparam T_SH_IR = 16'h0800;
localparam T_EX1_IR = 16'h1000;
localparam T_PA_IR = 16'h2000;
localparam T_EX2_IR = 16'h4000;
localparam T_UP_IR = 16'h8000;
localparam [7:0] HALF_LAST = `CONFIG_CLOCK_HALF_CYC - 1;

function is_master;
    input [2:0] m;
    begin
        is_master = (m == `MODE_MASTER_SPI) || (m == `MODE_MASTER_SERIAL);
    end
endfunction

function is_serial;
    input [2:0] m;
    begin
        is_serial = (m == `MODE_MASTER_SPI) || (m == `MODE_SLAVE_SPI) ||
            (m == `MODE_MASTER_SERIAL) || (m == `MODE_SLAVE_SERIAL);
    end
endfunction

reg [SYNC_W-1:0] sync1_q;
reg [SYNC_W-1:0] sync2_q;
reg [SYNC_W-1:0] prev_q;
reg [5:0] state_q;
reg [5:0] state_d;
reg [15:0] timer_q;
reg [15:0] taken_q;
reg [15:0] pushed_q;
reg [2:0] mode_q;
reg [1:0] lock_q;
reg [7:0] div_q;
reg [31:0] cmd_sr_q;
reg [5:0] cmd_left_q;
reg [7:0] shift_q;
reg [2:0] bitcnt_q;
reg [7:0] pend_q;
reg pend_valid_q;
reg [15:0] tap_q;
reg [15:0] tap_d;
reg [7:0] ir_sr_q;
reg [7:0] ir_q;
reg dr_q;
wire fifo_in_ready;

wire [SYNC_W-1:0] pins_raw = {program_request_n_in, ready_for_config_n_in, done_in,
    cfg_mode_in, config_clock_in, port_select_n_in, second_select_n_in,
    parallel_write_enable_n_in, config_data_in, tck_in, tms_in, tdi_in};

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and edge finders.

always @(posedge mclk_in)
begin
    if (!resetn_in)
    begin
        sync1_q <= {SYNC_W{1'b1}};
        sync2_q <= {SYNC_W{1'b1}};
        prev_q <= {SYNC_W{1'b1}};
    end
    else
    begin
        sync1_q <= pins_raw;
        sync2_q <= sync1_q;
        prev_q <= sync2_q;
    end
end

wire prog_n = sync2_q[20];
wire ready_pin = sync2_q[19];
wire done_pin = sync2_q[18];
wire [2:0] mode_pins = sync2_q[17:15];
wire sel_n = sync2_q[13];
wire sel2_n = sync2_q[12];
wire wr_n = sync2_q[11];
wire [7:0] data_pins = sync2_q[10:3];
wire tms = sync2_q[1];
wire tdi = sync2_q[0];
wire ready_rise = sync2_q[19] && !prev_q[19];
wire config_clock_rise = sync2_q[14] && !prev_q[14];
wire tck_rise = sync2_q[2] && !prev_q[2];
wire tck_fall = !sync2_q[2] && prev_q[2];

////////////////////////////////////////////////////////////////////////////////
// Configuration sequence.

wire loading = (state_q == ST_LOAD);
wire pin_src = loading && (lock_q != `LOCK_JTAG);
wire master = pin_src && is_master(mode_q);
wire room = (pushed_q != CONFIG_BYTES);

always @*
begin
    state_d = state_q;
    case (state_q)
        ST_CLEAR:
            if (timer_q == CLEAR_CYCLES - 16'h0001)
                state_d = ST_WAIT;
        ST_WAIT:
            if (ready_rise)
                state_d = ST_LOAD;
        ST_LOAD:
            if (taken_q == CONFIG_BYTES)
                state_d = ST_DONE;
        ST_DONE:
            if (done_pin)
                state_d = ST_START;
        ST_START:
            if (timer_q == STARTUP_CYCLES - 16'h0001)
                state_d = ST_USER;
        ST_USER:
            state_d = ST_USER;
        default:
            state_d = ST_CLEAR;
    endcase
    if (!prog_n)
        state_d = ST_CLEAR;
end

always @(posedge mclk_in)
begin
    if (!resetn_in)
    begin
        state_q <= ST_CLEAR;
        timer_q <= 16'h0000;
        mode_q <= `MODE_RESET;
        taken_q <= 16'h0000;
    end
    else
    begin
        state_q <= state_d;
        if (state_d != state_q || !prog_n)
            timer_q <= 16'h0000;
        else
            timer_q <= timer_q + 16'h0001;
        // Straps are read on this edge only.
        if (state_q == ST_WAIT && ready_rise)
            mode_q <= mode_pins;
        if (state_q == ST_CLEAR)
            taken_q <= 16'h0000;
        else if (cfg_byte_valid_out && cfg_byte_ready_in)
            taken_q <= taken_q + 16'h0001;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Configuration clock generator for master modes.

wire run = master && !pend_valid_q && room;
wire div_end = (div_q == HALF_LAST);
wire gen_tick = (run || config_clock_out) && div_end;
wire m_rise = gen_tick && !config_clock_out;
wire m_fall = gen_tick && config_clock_out;
wire link_rise = master ? m_rise : config_clock_rise;

always @(posedge mclk_in)
begin
    if (!resetn_in)
    begin
        div_q <= 8'h00;
        config_clock_out <= 1'b0;
    end
    else if (run || config_clock_out)
    begin
        // A stall lets the current high phase finish so the clock parks low.
        if (div_end)
        begin
            div_q <= 8'h00;
            config_clock_out <= !config_clock_out;
        end
        else
        begin
            div_q <= div_q + 8'h01;
        end
    end
    else
    begin
        div_q <= 8'h00;
    end
end

always @(posedge mclk_in)
begin
    if (!resetn_in || !loading)
    begin
        cmd_sr_q <= `FLASH_READ_CMD;
        cmd_left_q <= `CMD_BITS;
    end
    else if (mode_q == `MODE_MASTER_SPI && master)
    begin
        if (m_fall)
            cmd_sr_q <= {cmd_sr_q[30:0], 1'b0};
        if (m_rise && cmd_left_q != 6'h00)
            cmd_left_q <= cmd_left_q - 6'h01;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Bit and byte capture from the pins or the test port.

wire jtag_enable = tck_rise && (tap_q == T_UP_IR) && (ir_sr_q == `IR_CFG_ENABLE);
wire pin_bit = pin_src && is_serial(mode_q) && link_rise && room &&
    (mode_q != `MODE_MASTER_SPI || cmd_left_q == 6'h00) &&
    (mode_q != `MODE_SLAVE_SPI || !sel_n);
wire pin_byte = pin_src && (mode_q == `MODE_PARALLEL) && config_clock_rise && room &&
    !sel_n && !sel2_n && !wr_n;
wire jtag_bit = loading && (lock_q == `LOCK_JTAG) && (ir_q == `IR_CFG_LOAD) &&
    (tap_q == T_SH_DR) && tck_rise && room;
wire bit_take = pin_bit || jtag_bit;
wire bit_val = jtag_bit ? tdi :
    (mode_q == `MODE_MASTER_SPI ? data_pins[1] : data_pins[0]);
wire [7:0] shift_next = {shift_q[6:0], bit_val};
wire byte_done = (bit_take && bitcnt_q == 3'h7) || pin_byte;

always @(posedge mclk_in)
begin
    if (!resetn_in || state_q == ST_CLEAR)
    begin
        shift_q <= 8'h00;
        bitcnt_q <= 3'h0;
        pend_q <= 8'h00;
        pend_valid_q <= 1'b0;
        pushed_q <= 16'h0000;
        overrun_out <= 1'b0;
    end
    else
    begin
        if (bit_take)
        begin
            shift_q <= shift_next;
            bitcnt_q <= bitcnt_q + 3'h1;
        end
        if (byte_done)
        begin
            pend_q <= pin_byte ? data_pins : shift_next;
            pend_valid_q <= 1'b1;
            pushed_q <= pushed_q + 16'h0001;
            // A slave source that ignores busy loses the waiting byte.
            if (pend_valid_q && !fifo_in_ready)
                overrun_out <= 1'b1;
        end
        else if (fifo_in_ready)
        begin
            pend_valid_q <= 1'b0;
        end
    end
end

always @(posedge mclk_in)
begin
    if (!resetn_in)
        lock_q <= `LOCK_NONE;
    else if (lock_q == `LOCK_NONE)
    begin
        if (pin_bit || pin_byte)
            lock_q <= `LOCK_PINS;
        else if (jtag_enable)
            lock_q <= `LOCK_JTAG;
    end
end

config_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
) u_fifo (
    .clk_in(mclk_in),
    .resetn_in(resetn_in && state_q != ST_CLEAR),
    .in_data_in(pend_q),
    .in_valid_in(pend_valid_q),
    .in_ready_out(fifo_in_ready),
    .out_data_out(cfg_byte_out),
    .out_valid_out(cfg_byte_valid_out),
    .out_ready_in(cfg_byte_ready_in)
);

////////////////////////////////////////////////////////////////////////////////
// Test access port.

always @*
begin
    tap_d = tap_q;
    case (tap_q)
        T_RESET: tap_d = tms ? T_RESET : T_IDLE;
        T_IDLE: tap_d = tms ? T_SEL_DR : T_IDLE;
        T_SEL_DR: tap_d = tms ? T_SEL_IR : T_CAP_DR;
        T_CAP_DR: tap_d = tms ? T_EX1_DR : T_SH_DR;
        T_SH_DR: tap_d = tms ? T_EX1_DR : T_SH_DR;
        T_EX1_DR: tap_d = tms ? T_UP_DR : T_PA_DR;
        T_PA_DR: tap_d = tms ? T_EX2_DR : T_PA_DR;
        T_EX2_DR: tap_d = tms ? T_UP_DR : T_SH_DR;
        T_UP_DR: tap_d = tms ? T_SEL_DR : T_IDLE;
        T_SEL_IR: tap_d = tms ? T_RESET : T_CAP_IR;
        T_CAP_IR: tap_d = tms ? T_EX1_IR : T_SH_IR;
        T_SH_IR: tap_d = tms ? T_EX1_IR : T_SH_IR;
        T_EX1_IR: tap_d = tms ? T_UP_IR : T_PA_IR;
        T_PA_IR: tap_d = tms ? T_EX2_IR : T_PA_IR;
        T_EX2_IR: tap_d = tms ? T_UP_IR : T_SH_IR;
        T_UP_IR: tap_d = tms ? T_SEL_DR : T_IDLE;
        default: tap_d = T_RESET;
    endcase
end

always @(posedge mclk_in)
begin
    if (!resetn_in)
    begin
        tap_q <= T_RESET;
        ir_sr_q <= 8'h00;
        ir_q <= `IR_BYPASS;
        dr_q <= 1'b0;
        tdo_out <= 1'b0;
        tdo_oe_out <= 1'b0;
    end
    else
    begin
        if (tck_rise)
        begin
            tap_q <= tap_d;
            if (tap_q == T_RESET)
                ir_q <= `IR_BYPASS;
            if (tap_q == T_CAP_IR)
                ir_sr_q <= `IR_CAPTURE;
            if (tap_q == T_SH_IR)
                ir_sr_q <= {tdi, ir_sr_q[7:1]};
            if (tap_q == T_UP_IR)
                ir_q <= ir_sr_q;
            if (tap_q == T_CAP_DR)
                dr_q <= 1'b0;
            if (tap_q == T_SH_DR)
                dr_q <= tdi;
        end
        // Test data out changes on the falling test clock.
        if (tck_fall)
        begin
            tdo_out <= (tap_q == T_SH_IR) ? ir_sr_q[0] : dr_q;
            tdo_oe_out <= (tap_q == T_SH_IR) || (tap_q == T_SH_DR);
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pin drivers and status outputs.

always @(posedge mclk_in)
begin
    if (!resetn_in)
    begin
        ready_for_config_n_out <= 1'b0;
        ready_for_config_n_oe_out <= 1'b1;
        done_out <= 1'b0;
        done_oe_out <= 1'b1;
        config_clock_oe_out <= 1'b0;
        shared_busy_pin_out <= 1'b0;
        shared_busy_pin_oe_out <= 1'b0;
        serial_out_or_flash_select_out <= 1'b1;
        serial_out_or_flash_select_oe_out <= 1'b0;
        config_data_bit0_out <= 1'b0;
        config_data_bit0_oe_out <= 1'b0;
        cfg_mode_out <= `MODE_RESET;
        port_lock_out <= `LOCK_NONE;
        config_active_out <= 1'b1;
        user_mode_out <= 1'b0;
    end
    else
    begin
        ready_for_config_n_out <= 1'b0;
        ready_for_config_n_oe_out <= (state_d == ST_CLEAR);
        done_out <= 1'b0;
        done_oe_out <= (state_d == ST_CLEAR) || (state_d == ST_WAIT) ||
            (state_d == ST_LOAD);
        config_clock_oe_out <= master;
        shared_busy_pin_out <= pend_valid_q && !fifo_in_ready;
        shared_busy_pin_oe_out <= pin_src && (mode_q == `MODE_PARALLEL);
        if (master && mode_q == `MODE_MASTER_SPI)
            serial_out_or_flash_select_out <= 1'b0;
        else if (pin_bit)
            serial_out_or_flash_select_out <= bit_val;
        serial_out_or_flash_select_oe_out <= pin_src && is_serial(mode_q) &&
            (mode_q != `MODE_SLAVE_SPI);
        config_data_bit0_out <= cmd_sr_q[31];
        config_data_bit0_oe_out <= master && (mode_q == `MODE_MASTER_SPI);
        cfg_mode_out <= mode_q;
        port_lock_out <= lock_q;
        config_active_out <= (state_q != ST_USER);
        user_mode_out <= (state_q == ST_USER);
    end
end

endmodule // config_port_pin_control

// ### verification/config_host_model.sv
// Host model driving the configuration pins, serial or parallel.
// Assumes the bench resolves shared wires.
`timescale 1ns/1ps
module config_host_model (
    input wire busy_in,
    output reg clk_out,
    output reg [7:0] data_out,
    output reg select_n_out,
    output reg second_n_out,
    output reg write_n_out
);
    integer i;
    initial
    begin
        clk_out = 1'b0;
        data_out = 8'hA5;
        {select_n_out, second_n_out, write_n_out} = 3'h7;
    end
    // Clock idles low between bytes; released data is inverted.
    task send_byte(input bit par, input [7:0] b);
        begin
            for (i = 0; i < 40 && busy_in; i = i + 1)
                #48;
            select_n_out = 1'b0;
            second_n_out = !par;
            write_n_out = !par;
            for (i = 7; i >= (par ? 7 : 0); i = i - 1)
            begin
                data_out = par ? b : {7'h00, b[i]};
                #24 clk_out = 1'b1;
                #24 clk_out = 1'b0;
            end
            data_out = ~data_out;
            {select_n_out, second_n_out, write_n_out} = 3'h7;
            #24;
        end
    endtask
endmodule // config_host_model

// ### verification/config_port_pin_control_assertions.sv
// Checker bound to the pin controller's ports.
// Assumes the shared defines header.
`timescale 1ns/1ps
`include "config_port_defines.vh"
module config_port_pin_control_assertions (
    input wire mclk_in,
    input wire resetn_in,
    input wire program_request_n_in,
    input wire [2:0] cfg_mode_in,
    input wire ready_for_config_n_in,
    input wire ready_for_config_n_oe_out,
    input wire done_in,
    input wire done_oe_out,
    input wire config_clock_out,
    input wire config_clock_oe_out,
    input wire shared_busy_pin_oe_out,
    input wire serial_out_or_flash_select_oe_out,
    input wire config_data_bit0_oe_out,
    input wire [2:0] cfg_mode_out,
    input wire [1:0] port_lock_out,
    input wire config_active_out,
    input wire user_mode_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!resetn_in);
    sequence s_ready_settled;
        (ready_for_config_n_in && program_request_n_in) [*8];
    endsequence
    sequence s_strap_capture;
        $rose(ready_for_config_n_in) ##1 (program_request_n_in && $stable(cfg_mode_in)) [*6];
    endsequence
    sequence s_clock_high;
        (config_clock_out || !config_clock_oe_out) [*8] ##1
            (config_clock_out || !config_clock_oe_out) [*2];
    endsequence
    a_mode_capture: assert property (s_strap_capture |-> cfg_mode_out == cfg_mode_in)
        else $error("mode capture");
    a_mode_hold: assert property (s_ready_settled |-> $stable(cfg_mode_out))
        else $error("mode moved");
    a_restart_clears: assert property (!program_request_n_in [*5] |-> ready_for_config_n_oe_out && done_oe_out)
        else $error("no restart");
    a_done_order: assert property ($fell(done_oe_out) |-> !ready_for_config_n_oe_out && config_active_out)
        else $error("done order");
    a_user_entry: assert property ($rose(user_mode_out) |-> $past(done_in, 5) && !config_active_out)
        else $error("user entry");
    a_pins_free: assert property (user_mode_out |-> !(shared_busy_pin_oe_out || config_clock_oe_out || serial_out_or_flash_select_oe_out || config_data_bit0_oe_out))
        else $error("pin driven");
    a_clock_dir: assert property (config_clock_oe_out |-> cfg_mode_out == `MODE_MASTER_SPI || cfg_mode_out == `MODE_MASTER_SERIAL)
        else $error("clock dir");
    a_clock_half: assert property ($rose(config_clock_out) |-> s_clock_high ##1 !config_clock_out)
        else $error("clock half");
    a_busy_mode: assert property (shared_busy_pin_oe_out |-> cfg_mode_out == `MODE_PARALLEL)
        else $error("busy mode");
    a_data0_dir: assert property (config_data_bit0_oe_out |-> cfg_mode_out == `MODE_MASTER_SPI)
        else $error("data0 dir");
    a_lock_hold: assert property (port_lock_out != `LOCK_NONE |=> $stable(port_lock_out))
        else $error("lock moved");
endmodule // config_port_pin_control_assertions
bind config_port_pin_control config_port_pin_control_assertions chk (.*);

// ### verification/testbench.sv
// Self-checking bench for the pin controller.
// Assumes host model and checker compiled alongside.
`timescale 1ns/1ps
`include "config_port_defines.vh"
module testbench;
    localparam [15:0] NBYTES = 16'h0018;
    reg mclk_in = 1'b0;
    reg resetn_in = 1'b0;
    reg prog_n = 1'b1;
    reg [2:0] straps = 3'h3;
    reg tck = 1'b0;
    reg tms = 1'b1;
    reg tdi = 1'b0;
    reg sink_en = 1'b0;
    reg tdo_en = 1'b0;
    reg [7:0] tdo_word = 8'h00;
    integer n_fail = 0;
    integer checks = 0;
    integer cycles = 0;
    reg [7:0] sent[$];
    reg [7:0] got[$];
    wire ready_oe, done_oe, clk_out, clk_oe, busy_out, busy_oe, so_out, so_oe, d0_out, d0_oe;
    wire tdo, tdo_oe, valid, active, user, overrun, h_clk, h_sel, h_sel2, h_wr;
    wire [7:0] cbyte, h_data;
    wire [2:0] mode;
    wire [1:0] lock;
    config_host_model host (.busy_in(busy_oe & busy_out), .clk_out(h_clk), .data_out(h_data),
        .select_n_out(h_sel), .second_n_out(h_sel2), .write_n_out(h_wr));
    config_port_pin_control #(.CONFIG_BYTES(NBYTES), .CLEAR_CYCLES(16'h0008),
        .STARTUP_CYCLES(16'h0004)) dut (
        .mclk_in, .resetn_in, .program_request_n_in(prog_n),
        .cfg_mode_in(straps), .ready_for_config_n_in(!ready_oe), .ready_for_config_n_out(),
        .ready_for_config_n_oe_out(ready_oe), .done_in(!done_oe), .done_out(),
        .done_oe_out(done_oe), .config_clock_in(clk_oe ? clk_out : h_clk),
        .config_clock_out(clk_out), .config_clock_oe_out(clk_oe), .port_select_n_in(h_sel),
        .second_select_n_in(h_sel2), .parallel_write_enable_n_in(h_wr),
        .shared_busy_pin_out(busy_out), .shared_busy_pin_oe_out(busy_oe),
        .serial_out_or_flash_select_out(so_out), .serial_out_or_flash_select_oe_out(so_oe),
        .config_data_in({h_data[7:1], d0_oe ? d0_out : h_data[0]}),
        .config_data_bit0_out(d0_out), .config_data_bit0_oe_out(d0_oe), .tck_in(tck),
        .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .cfg_byte_out(cbyte),
        .cfg_byte_valid_out(valid), .cfg_byte_ready_in(sink_en), .cfg_mode_out(mode),
        .port_lock_out(lock), .config_active_out(active), .user_mode_out(user),
        .overrun_out(overrun));
    always #2.5 mclk_in = !mclk_in;
    always @(posedge mclk_in)
    begin
        cycles = cycles + 1;
        if (valid === 1'b1 && sink_en)
            got.push_back(cbyte);
        if (cycles == 20000)
        begin
            n_fail = n_fail + 1;
            report_and_stop;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task cmp(input string what, input [31:0] e, input [31:0] s);
        begin
            checks = checks + 1;
            if (s !== e)
            begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED %s expected %h seen %h", what, e, s);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d n_fail %0d", checks, n_fail);
            if (n_fail == 0 && checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task restart(input [2:0] m);
        integer j;
        begin
            @(negedge mclk_in);
            prog_n = 1'b0;
            straps = m;
            repeat (6) @(negedge mclk_in);
            cmp("restart", 2, {ready_oe, user});
            prog_n = 1'b1;
            for (j = 0; j < 100 && ready_oe; j = j + 1)
                @(negedge mclk_in);
            cmp("ready", 0, ready_oe);
            repeat (8) @(negedge mclk_in);
            cmp("mode", m, mode);
            straps = ~m;
        end
    endtask
    task send(input bit par, input [7:0] b);
        begin
            sent.push_back(b);
            host.send_byte(par, b);
        end
    endtask
    task finish_load(input [2:0] m);
        integer j;
        begin
            for (j = 0; j < 3000 && !user; j = j + 1)
                @(negedge mclk_in);
            cmp("user", 2, {user, active});
            cmp("mode kept", m, mode);
            cmp("overrun", 0, overrun);
            cmp("count", sent.size(), got.size());
            for (j = 0; j < sent.size() && j < got.size(); j = j + 1)
                cmp("byte", sent[j], got[j]);
            sent.delete();
            got.delete();
        end
    endtask
    task jstep(input bit m, input bit d);
        begin
            tms = m;
            tdi = d;
            repeat (5) @(negedge mclk_in);
            tdo_word = {tdo, tdo_word[7:1]};
            tdo_en = tdo_en | tdo_oe;
            tck = 1'b1;
            repeat (5) @(negedge mclk_in);
            tck = 1'b0;
        end
    endtask
    task ir_load(input [7:0] code);
        integer j;
        begin
            for (j = 0; j < 10; j = j + 1)
                jstep(j < 5 || j == 6 || j == 7, 1'b0);
            tdo_en = 1'b0;
            for (j = 0; j < 8; j = j + 1)
                jstep(j == 7, code[j]);
            cmp("ir capture", 8'h01, tdo_word);
            cmp("tdo oe", 1, tdo_en);
            jstep(1'b1, 1'b0);
            jstep(1'b0, 1'b0);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_slave_serial;
        integer j;
        begin
            restart(`MODE_SLAVE_SERIAL);
            for (j = 0; j < NBYTES; j = j + 1)
            begin
                @(negedge mclk_in);
                sink_en = (j > 3);
                send(1'b0, 8'h3C ^ j[7:0]);
            end
            @(negedge mclk_in);
            finish_load(`MODE_SLAVE_SERIAL);
            cmp("lock pins", `LOCK_PINS, lock);
        end
    endtask
    task t_parallel;
        integer j;
        begin
            restart(`MODE_PARALLEL);
            sink_en = 1'b0;
            for (j = 0; j < 20 && !(busy_oe & busy_out); j = j + 1)
            begin
                send(1'b1, 8'hC0 + j[7:0]);
                repeat (8) @(negedge mclk_in);
            end
            cmp("busy", 1, busy_oe & busy_out);
            cmp("fill depth", 1, j > 15);
            sink_en = 1'b1;
            for (j = j; j < NBYTES; j = j + 1)
                send(1'b1, 8'hC0 + j[7:0]);
            @(negedge mclk_in);
            finish_load(`MODE_PARALLEL);
        end
    endtask
    task t_master;
        integer j;
        begin
            for (j = 0; j < 3; j = j + 1)
            begin
                restart(j == 0 ? `MODE_MASTER_SPI : j == 1 ? `MODE_MASTER_SERIAL : `MODE_SLAVE_SPI);
                repeat (40) @(negedge mclk_in);
                cmp("clock oe", j != 2, clk_oe);
                cmp("data0 oe", j == 0, d0_oe);
                if (j == 0)
                    cmp("flash select", 2, {so_oe, so_out});
            end
        end
    endtask
    task t_jtag;
        begin
            @(negedge mclk_in);
            resetn_in = 1'b0;
            repeat (3) @(negedge mclk_in);
            resetn_in = 1'b1;
            ir_load(`IR_CFG_ENABLE);
            cmp("tap lock", `LOCK_JTAG, lock);
            restart(`MODE_SLAVE_SERIAL);
            got.delete();
            host.send_byte(1'b0, 8'h81);
            repeat (20) @(negedge mclk_in);
            cmp("pins refused", 0, got.size());
            cmp("lock kept", `LOCK_JTAG, lock);
        end
    endtask
    initial
    begin
        repeat (12) @(negedge mclk_in);
        cmp("reset", 16'hC0BC, {ready_oe, done_oe, clk_oe, busy_oe, so_oe, d0_oe,
            tdo_oe, valid, so_out, user, active, mode, lock});
        resetn_in = 1'b1;
        t_slave_serial;
        t_parallel;
        t_master;
        t_jtag;
        report_and_stop;
    end
endmodule // testbench
